// File: src/acf_pkg.sv
package acf_pkg;

    // ------------------------------------------------------------
    // Widths and flag positions
    // ------------------------------------------------------------
    localparam int DATA_W    = 8;
    localparam int FLAG_W    = 5;
    localparam int BIT_SEL_W = 3;

    localparam int POS_CARRY    = 0;
    localparam int POS_NIBBLE   = 1;
    localparam int POS_ZERO     = 2;
    localparam int POS_OVERFLOW = 3;
    localparam int POS_NEGATIVE = 4;

    // Flags power up unknown; this core still defines them
    localparam logic [FLAG_W-1:0] FLAGS_RESET  = 5'h00;
    localparam logic [DATA_W-1:0] DATA_RESET   = 8'h00;
    localparam logic [2:0]        UNUSED_BITS  = 3'h0;

    // ------------------------------------------------------------
    // Which flags each kind of operation may change
    // ------------------------------------------------------------
    localparam logic [FLAG_W-1:0] MASK_ALL   = 5'h1f;
    localparam logic [FLAG_W-1:0] MASK_LOGIC = 5'h14;
    localparam logic [FLAG_W-1:0] MASK_ZERO  = 5'h04;
    localparam logic [FLAG_W-1:0] MASK_ROT   = 5'h15;
    localparam logic [FLAG_W-1:0] MASK_NONE  = 5'h00;

    typedef enum logic [3:0] {
        ACF_ADD,
        ACF_SUB,
        ACF_AND,
        ACF_IOR,
        ACF_XOR,
        ACF_CLEAR,
        ACF_WORK_MOVE,
        ACF_FILE_MOVE,
        ACF_BIT_CLEAR,
        ACF_BIT_SET,
        ACF_SWAP,
        ACF_ROT_RIGHT,
        ACF_ROT_LEFT
    } acf_op_t;

endpackage : acf_pkg

// File: src/acf_alu_if.sv
`timescale 1ns/1ps
interface acf_alu_if;
    acf_pkg::acf_op_t                     op;
    logic [acf_pkg::BIT_SEL_W-1:0]        bit_sel;
    logic [acf_pkg::DATA_W-1:0]           file_opd;
    logic [acf_pkg::DATA_W-1:0]           work_opd;
    logic                                 carry_in;
    logic [acf_pkg::DATA_W-1:0]           result;
    logic [acf_pkg::FLAG_W-1:0]           flags_out;
    logic [acf_pkg::FLAG_W-1:0]           flag_mask;

    modport alu  (input op, bit_sel, file_opd, work_opd, carry_in,
                  output result, flags_out, flag_mask);
    modport core (output op, bit_sel, file_opd, work_opd, carry_in,
                  input result, flags_out, flag_mask);
endinterface : acf_alu_if

// File: src/acf_alu.sv
`timescale 1ns/1ps
module acf_alu (
    acf_alu_if.alu alu
);

    // ------------------------------------------------------------
    // Flag mask decode
    // ------------------------------------------------------------
    function automatic logic [acf_pkg::FLAG_W-1:0] flag_mask_of(input acf_pkg::acf_op_t op);
        unique case (op)
            acf_pkg::ACF_ADD,
            acf_pkg::ACF_SUB:       flag_mask_of = acf_pkg::MASK_ALL;
            acf_pkg::ACF_AND,
            acf_pkg::ACF_IOR,
            acf_pkg::ACF_XOR:       flag_mask_of = acf_pkg::MASK_LOGIC;
            acf_pkg::ACF_CLEAR:     flag_mask_of = acf_pkg::MASK_ZERO;
            acf_pkg::ACF_ROT_RIGHT,
            acf_pkg::ACF_ROT_LEFT:  flag_mask_of = acf_pkg::MASK_ROT;
            default:                flag_mask_of = acf_pkg::MASK_NONE;
        endcase
    endfunction : flag_mask_of

    logic [acf_pkg::DATA_W-1:0] addend;
    logic                       add_cin;
    logic [acf_pkg::DATA_W:0]   sum;
    logic [4:0]                 nib_sum;
    logic [acf_pkg::DATA_W-1:0] res;
    logic                       c_out;

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    always_comb begin
        addend  = (alu.op == acf_pkg::ACF_SUB) ? ~alu.work_opd : alu.work_opd;
        add_cin = (alu.op == acf_pkg::ACF_SUB);
        sum     = {1'b0, alu.file_opd} + {1'b0, addend} + {8'h00, add_cin};
        nib_sum = {1'b0, alu.file_opd[3:0]} + {1'b0, addend[3:0]} + {4'h0, add_cin};
        c_out   = sum[acf_pkg::DATA_W];
        res     = sum[acf_pkg::DATA_W-1:0];
        unique case (alu.op)
            acf_pkg::ACF_ADD,
            acf_pkg::ACF_SUB:       res = sum[acf_pkg::DATA_W-1:0];
            acf_pkg::ACF_AND:       res = alu.file_opd & alu.work_opd;
            acf_pkg::ACF_IOR:       res = alu.file_opd | alu.work_opd;
            acf_pkg::ACF_XOR:       res = alu.file_opd ^ alu.work_opd;
            acf_pkg::ACF_CLEAR:     res = acf_pkg::DATA_RESET;
            acf_pkg::ACF_WORK_MOVE: res = alu.work_opd;
            acf_pkg::ACF_FILE_MOVE: res = alu.file_opd;
            acf_pkg::ACF_BIT_CLEAR: begin
                res = alu.file_opd;
                res[alu.bit_sel] = 1'b0;
            end
            acf_pkg::ACF_BIT_SET: begin
                res = alu.file_opd;
                res[alu.bit_sel] = 1'b1;
            end
            acf_pkg::ACF_SWAP:      res = {alu.file_opd[3:0], alu.file_opd[7:4]};
            // rotate loads carry from source edge bit
            acf_pkg::ACF_ROT_RIGHT: begin
                res   = {alu.carry_in, alu.file_opd[7:1]};
                c_out = alu.file_opd[0];
            end
            acf_pkg::ACF_ROT_LEFT: begin
                res   = {alu.file_opd[6:0], alu.carry_in};
                c_out = alu.file_opd[7];
            end
            default:                res = sum[acf_pkg::DATA_W-1:0];
        endcase
    end

    // ------------------------------------------------------------
    // Flag outputs
    // ------------------------------------------------------------
    always_comb begin
        alu.result    = res;
        alu.flag_mask = flag_mask_of(alu.op);
        // carry out of the top bit, or for a rotate the bit shifted out
        alu.flags_out[acf_pkg::POS_CARRY]    = c_out;
        // carry out of the low nibble
        alu.flags_out[acf_pkg::POS_NIBBLE]   = nib_sum[4];
        alu.flags_out[acf_pkg::POS_ZERO]     = (res == acf_pkg::DATA_RESET);
        // signed overflow, same signs in, other sign out
        alu.flags_out[acf_pkg::POS_OVERFLOW] = (alu.file_opd[7] == addend[7])
                                               && (res[7] != alu.file_opd[7]);
        alu.flags_out[acf_pkg::POS_NEGATIVE] = res[7];
    end

endmodule : acf_alu

// File: src/acf_flag_reg.sv
`timescale 1ns/1ps
module acf_flag_reg (
    input  wire logic                          clk_sys,
    input  wire logic                          reset_n,
    input  wire logic                          op_valid,
    input  wire acf_pkg::acf_op_t              op_code,
    input  wire logic [acf_pkg::BIT_SEL_W-1:0] op_bit_sel,
    input  wire logic [acf_pkg::DATA_W-1:0]    op_file,
    input  wire logic [acf_pkg::DATA_W-1:0]    op_work,
    input  wire logic                          op_dest_flags,
    output logic [acf_pkg::DATA_W-1:0]         result_data,
    output logic                               result_write,
    output logic [acf_pkg::FLAG_W-1:0]         alu_condition_flags,
    output logic [acf_pkg::DATA_W-1:0]         flag_read_data
);

    acf_alu_if alu_bus ();

    logic [acf_pkg::FLAG_W-1:0] next_flags;
    logic [acf_pkg::DATA_W-1:0] next_result_data;
    logic                       next_result_write;
    logic [acf_pkg::DATA_W-1:0] next_read_data;
    logic [acf_pkg::DATA_W-1:0] flags_as_byte;

    // ------------------------------------------------------------
    // Operand steering
    // ------------------------------------------------------------
    assign flags_as_byte = {acf_pkg::UNUSED_BITS, alu_condition_flags};

    // flag register serves as source when it is destination
    assign alu_bus.file_opd = op_dest_flags ? flags_as_byte : op_file;
    assign alu_bus.work_opd = op_work;
    assign alu_bus.op       = op_code;
    assign alu_bus.bit_sel  = op_bit_sel;
    assign alu_bus.carry_in = alu_condition_flags[acf_pkg::POS_CARRY];

    acf_alu u_alu (
        .alu (alu_bus)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_flags        = alu_condition_flags;
        next_result_data  = result_data;
        next_result_write = 1'b0;
        if (op_valid) begin
            if (op_dest_flags && (alu_bus.flag_mask != acf_pkg::MASK_NONE)) begin
                // result dropped, masked flags take the update
                // clear has only the zero flag in its mask
                next_flags = (alu_condition_flags & ~alu_bus.flag_mask)
                             | (alu_bus.flags_out & alu_bus.flag_mask);
            end else if (op_dest_flags) begin
                // flag-neutral ops write the register plainly
                next_flags = alu_bus.result[acf_pkg::FLAG_W-1:0];
            end else begin
                next_result_data  = alu_bus.result;
                next_result_write = 1'b1;
                // empty mask keeps flags for move, swap, bit ops
                next_flags = (alu_condition_flags & ~alu_bus.flag_mask)
                             | (alu_bus.flags_out & alu_bus.flag_mask);
            end
        end
        next_read_data = {acf_pkg::UNUSED_BITS, next_flags};
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            alu_condition_flags <= acf_pkg::FLAGS_RESET;
            result_data         <= acf_pkg::DATA_RESET;
            result_write        <= 1'b0;
            flag_read_data      <= acf_pkg::DATA_RESET;
        end else begin
            alu_condition_flags <= next_flags;
            result_data         <= next_result_data;
            result_write        <= next_result_write;
            flag_read_data      <= next_read_data;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    logic [acf_pkg::DATA_W:0] chk_add_sum;
    logic [4:0]               chk_nib_sum;
    logic [acf_pkg::DATA_W:0] chk_sub_sum;
    logic                     chk_no_borrow;
    logic [4:0]               chk_sub_nib;
    assign chk_add_sum = {1'b0, op_file} + {1'b0, op_work};
    assign chk_nib_sum = {1'b0, op_file[3:0]} + {1'b0, op_work[3:0]};
    assign chk_sub_sum = {1'b0, op_file} + {1'b0, ~op_work} + 9'h001;
    assign chk_no_borrow = (op_file >= op_work);
    assign chk_sub_nib = {1'b0, op_file[3:0]} + {1'b0, ~op_work[3:0]} + 5'h01;

    chk_flag_dest_nowrite: assert property (
        op_valid && op_dest_flags |=> !result_write
            && (result_data == $past(result_data)))
        else $error("Result written while flags were destination");

    chk_clear_zero_only: assert property (
        op_valid && op_dest_flags && op_code == acf_pkg::ACF_CLEAR
        |=> alu_condition_flags[acf_pkg::POS_ZERO]
            && ((alu_condition_flags & 5'h1b) == ($past(alu_condition_flags) & 5'h1b)))
        else $error("Clear of flag register changed more than zero flag");

    chk_neutral_keeps: assert property (
        op_valid && !op_dest_flags && (op_code inside {acf_pkg::ACF_BIT_CLEAR,
            acf_pkg::ACF_BIT_SET, acf_pkg::ACF_SWAP, acf_pkg::ACF_WORK_MOVE,
            acf_pkg::ACF_FILE_MOVE})
        |=> $stable(alu_condition_flags) && result_write)
        else $error("Flag-neutral operation changed flags");

    chk_sub_borrow: assert property (
        op_valid && !op_dest_flags && op_code == acf_pkg::ACF_SUB
        |=> alu_condition_flags[acf_pkg::POS_CARRY] == $past(chk_no_borrow)
            && result_data == $past(chk_sub_sum[7:0]))
        else $error("Subtract borrow polarity wrong");

    chk_negative_top: assert property (
        op_valid && !op_dest_flags && op_code inside {acf_pkg::ACF_ADD, acf_pkg::ACF_AND}
        |=> alu_condition_flags[acf_pkg::POS_NEGATIVE] == result_data[7])
        else $error("Negative flag does not follow result");

    chk_overflow_add: assert property (
        op_valid && !op_dest_flags && op_code == acf_pkg::ACF_ADD
        |=> alu_condition_flags[acf_pkg::POS_OVERFLOW] ==
            (($past(op_file[7]) == $past(op_work[7])) && (result_data[7] != $past(op_file[7]))))
        else $error("Overflow flag wrong after add");

    chk_carry_add: assert property (
        op_valid && !op_dest_flags && op_code == acf_pkg::ACF_ADD
        |=> alu_condition_flags[acf_pkg::POS_CARRY] == $past(chk_add_sum[8]))
        else $error("Carry flag wrong after add");

    chk_rotate_carry: assert property (
        op_valid && !op_dest_flags && op_code == acf_pkg::ACF_ROT_RIGHT
        |=> alu_condition_flags[acf_pkg::POS_CARRY] == $past(op_file[0])
            && result_data[7] == $past(alu_condition_flags[acf_pkg::POS_CARRY]))
        else $error("Rotate right carry wrong");

    chk_read_view: assert property (
        ##1 flag_read_data == {3'h0, alu_condition_flags})
        else $error("Read view differs from flags");

    chk_zero_result: assert property (
        op_valid && !op_dest_flags && op_code inside {acf_pkg::ACF_XOR, acf_pkg::ACF_SUB}
        |=> alu_condition_flags[acf_pkg::POS_ZERO] == (result_data == 8'h00))
        else $error("Zero flag does not match result");

    chk_nibble_carry: assert property (
        op_valid && !op_dest_flags && op_code == acf_pkg::ACF_ADD
        |=> alu_condition_flags[acf_pkg::POS_NIBBLE] == $past(chk_nib_sum[4]))
        else $error("Nibble carry wrong after add");

    chk_sub_digit_borrow: assert property (
        op_valid && !op_dest_flags && op_code == acf_pkg::ACF_SUB
        |=> alu_condition_flags[acf_pkg::POS_NIBBLE] == $past(chk_sub_nib[4]))
        else $error("Digit borrow polarity wrong");

    chk_overflow_sub: assert property (
        op_valid && !op_dest_flags && op_code == acf_pkg::ACF_SUB
        |=> alu_condition_flags[acf_pkg::POS_OVERFLOW] ==
            (($past(op_file[7]) != $past(op_work[7])) && (result_data[7] != $past(op_file[7]))))
        else $error("Overflow flag wrong after subtract");

    chk_rotate_left: assert property (
        op_valid && !op_dest_flags && op_code == acf_pkg::ACF_ROT_LEFT
        |=> alu_condition_flags[acf_pkg::POS_CARRY] == $past(op_file[7])
            && result_data[0] == $past(alu_condition_flags[acf_pkg::POS_CARRY]))
        else $error("Rotate left carry wrong");

    chk_negative_sub_rot: assert property (
        op_valid && !op_dest_flags && op_code inside {acf_pkg::ACF_SUB,
            acf_pkg::ACF_ROT_RIGHT, acf_pkg::ACF_ROT_LEFT}
        |=> alu_condition_flags[acf_pkg::POS_NEGATIVE] == result_data[7])
        else $error("Negative flag does not follow result");

    chk_zero_rotate: assert property (
        op_valid && !op_dest_flags && op_code inside {acf_pkg::ACF_ROT_RIGHT,
            acf_pkg::ACF_ROT_LEFT}
        |=> alu_condition_flags[acf_pkg::POS_ZERO] == (result_data == 8'h00))
        else $error("Zero flag wrong after rotate");

    chk_clear_sets_zero: assert property (
        op_valid && !op_dest_flags && op_code == acf_pkg::ACF_CLEAR
        |=> alu_condition_flags[acf_pkg::POS_ZERO] && (result_data == 8'h00))
        else $error("Clear did not give zero");

    chk_logic_keeps_carry: assert property (
        op_valid && op_code inside {acf_pkg::ACF_AND, acf_pkg::ACF_IOR, acf_pkg::ACF_XOR}
        |=> $stable(alu_condition_flags[acf_pkg::POS_CARRY]))
        else $error("Logic operation changed carry");

    chk_dest_work_move: assert property (
        op_valid && op_dest_flags && op_code == acf_pkg::ACF_WORK_MOVE
        |=> alu_condition_flags == $past(op_work[4:0]))
        else $error("Move into flag register lost data");

    chk_dest_file_move: assert property (
        op_valid && op_dest_flags && op_code == acf_pkg::ACF_FILE_MOVE
        |=> $stable(alu_condition_flags))
        else $error("Self move changed flag register");

    chk_write_on_data: assert property (
        op_valid && !op_dest_flags |=> result_write)
        else $error("Result not written for data destination");

    chk_write_only_data: assert property (
        !op_valid || op_dest_flags |=> !result_write)
        else $error("Result written without data destination");

endmodule : acf_flag_reg

// File: dv/acf_core_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Core side: issues one instruction per falling edge
// ------------------------------------------------------------
module acf_core_model (
    input  wire logic                          clk_sys,
    output logic                               op_valid,
    output acf_pkg::acf_op_t                   op_code,
    output logic [acf_pkg::BIT_SEL_W-1:0]      op_bit_sel,
    output logic [acf_pkg::DATA_W-1:0]         op_file,
    output logic [acf_pkg::DATA_W-1:0]         op_work,
    output logic                               op_dest_flags
);
    initial begin
        op_valid      = 1'b0;
        op_code       = acf_pkg::ACF_ADD;
        op_bit_sel    = 3'h0;
        op_file       = 8'h00;
        op_work       = 8'h00;
        op_dest_flags = 1'b0;
    end

    task automatic issue(input acf_pkg::acf_op_t op, input logic [2:0] bs,
                         input logic [7:0] f, input logic [7:0] w, input logic d);
        @(negedge clk_sys);
        op_valid      = 1'b1;
        op_code       = op;
        op_bit_sel    = bs;
        op_file       = f;
        op_work       = w;
        op_dest_flags = d;
    endtask : issue

    // Released operands flip so a stale value is never mistaken for live data
    task automatic idle();
        @(negedge clk_sys);
        op_valid      = 1'b0;
        op_file       = ~op_file;
        op_work       = ~op_work;
        op_dest_flags = ~op_dest_flags;
    endtask : idle
endmodule : acf_core_model

// File: dv/tb_alu_condition_flag_register.sv
`timescale 1ns/1ps
module tb_alu_condition_flag_register;
    logic                clk_sys;
    logic                reset_n;
    logic                op_valid;
    acf_pkg::acf_op_t    op_code;
    logic [2:0]          op_bit_sel;
    logic [7:0]          op_file;
    logic [7:0]          op_work;
    logic                op_dest_flags;
    logic [7:0]          result_data;
    logic                result_write;
    logic [4:0]          alu_condition_flags;
    logic [7:0]          flag_read_data;
    logic [4:0]          ef;
    logic [7:0]          er;
    int                  fails;
    int                  n_compared;

    acf_core_model acf_core_model_i (.clk_sys(clk_sys), .op_valid(op_valid), .op_code(op_code),
        .op_bit_sel(op_bit_sel), .op_file(op_file), .op_work(op_work),
        .op_dest_flags(op_dest_flags));
    acf_flag_reg acf_flag_reg_i (.clk_sys(clk_sys), .reset_n(reset_n), .op_valid(op_valid),
        .op_code(op_code), .op_bit_sel(op_bit_sel), .op_file(op_file), .op_work(op_work),
        .op_dest_flags(op_dest_flags), .result_data(result_data), .result_write(result_write),
        .alu_condition_flags(alu_condition_flags), .flag_read_data(flag_read_data));

    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Checking and reference model
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Returns {result, change mask, new flags}
    function automatic logic [17:0] model(input acf_pkg::acf_op_t op, input logic [7:0] a,
                                          input logic [7:0] w, input logic [4:0] f,
                                          input logic [2:0] bs);
        logic [7:0] b;
        logic [8:0] s;
        logic [4:0] nb;
        logic [7:0] r;
        logic [4:0] m;
        logic       c;
        b  = (op == acf_pkg::ACF_SUB) ? ~w : w;
        s  = {1'b0, a} + {1'b0, b} + {8'h00, op == acf_pkg::ACF_SUB};
        nb = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, op == acf_pkg::ACF_SUB};
        c  = s[8];
        m  = acf_pkg::MASK_NONE;
        r  = a;
        case (op)
            acf_pkg::ACF_ADD, acf_pkg::ACF_SUB: begin r = s[7:0]; m = acf_pkg::MASK_ALL; end
            acf_pkg::ACF_AND:       begin r = a & w; m = acf_pkg::MASK_LOGIC; end
            acf_pkg::ACF_IOR:       begin r = a | w; m = acf_pkg::MASK_LOGIC; end
            acf_pkg::ACF_XOR:       begin r = a ^ w; m = acf_pkg::MASK_LOGIC; end
            acf_pkg::ACF_CLEAR:     begin r = 8'h00; m = acf_pkg::MASK_ZERO; end
            acf_pkg::ACF_WORK_MOVE: r = w;
            acf_pkg::ACF_BIT_CLEAR: r = a & ~(8'h01 << bs);
            acf_pkg::ACF_BIT_SET:   r = a | (8'h01 << bs);
            acf_pkg::ACF_SWAP:      r = {a[3:0], a[7:4]};
            acf_pkg::ACF_ROT_RIGHT: begin r = {f[0], a[7:1]}; c = a[0]; m = acf_pkg::MASK_ROT; end
            acf_pkg::ACF_ROT_LEFT:  begin r = {a[6:0], f[0]}; c = a[7]; m = acf_pkg::MASK_ROT; end
            default:                r = a;
        endcase
        return {r, m, (f & ~m) | ({r[7], (a[7] == b[7]) && (r[7] != a[7]), r == 8'h00,
                                   nb[4], c} & m)};
    endfunction : model

    task automatic do_op(input acf_pkg::acf_op_t op, input logic [2:0] bs,
                         input logic [7:0] f, input logic [7:0] w, input logic d);
        logic [17:0] x;
        x = model(op, d ? {3'h0, ef} : f, w, ef, bs);
        acf_core_model_i.issue(op, bs, f, w, d);
        @(posedge clk_sys);
        #1;
        if (d) ef = (x[9:5] == acf_pkg::MASK_NONE) ? x[14:10] : x[4:0];
        else begin ef = x[4:0]; er = x[17:10]; end
        check(result_data, er);
        check({7'h0, result_write}, {7'h0, !d});
        check({3'h0, alu_condition_flags}, {3'h0, ef});
        check(flag_read_data, {3'h0, ef});
    endtask : do_op

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        // Drop any op still held so it is not taken again after reset
        acf_core_model_i.idle();
        reset_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        ef = acf_pkg::FLAGS_RESET;
        er = acf_pkg::DATA_RESET;
        check({3'h0, alu_condition_flags}, {3'h0, ef});
        check(flag_read_data, 8'h00);
        check(result_data, er);
        check({7'h0, result_write}, 8'h00);
        @(negedge clk_sys);
        reset_n = 1'b1;
    endtask : t_reset

    task automatic t_arith();
        do_op(acf_pkg::ACF_ADD, 3'h0, 8'h7f, 8'h01, 1'b0);
        check({3'h0, alu_condition_flags}, 8'h1a);
        do_op(acf_pkg::ACF_ADD, 3'h0, 8'hff, 8'h01, 1'b0);
        do_op(acf_pkg::ACF_ADD, 3'h0, 8'h08, 8'h08, 1'b0);
        do_op(acf_pkg::ACF_SUB, 3'h0, 8'h05, 8'h05, 1'b0);
        do_op(acf_pkg::ACF_SUB, 3'h0, 8'h00, 8'h01, 1'b0);
        do_op(acf_pkg::ACF_SUB, 3'h0, 8'h80, 8'h01, 1'b0);
        acf_core_model_i.idle();
        @(posedge clk_sys);
        #1;
        check({7'h0, result_write}, 8'h00);
    endtask : t_arith

    task automatic t_logic_rot();
        do_op(acf_pkg::ACF_AND, 3'h0, 8'hff, 8'h0f, 1'b0);
        do_op(acf_pkg::ACF_IOR, 3'h0, 8'h00, 8'h00, 1'b0);
        do_op(acf_pkg::ACF_XOR, 3'h0, 8'h80, 8'h00, 1'b0);
        do_op(acf_pkg::ACF_ROT_LEFT, 3'h0, 8'h81, 8'h00, 1'b0);
        do_op(acf_pkg::ACF_ROT_RIGHT, 3'h0, 8'h02, 8'h00, 1'b0);
        do_op(acf_pkg::ACF_ROT_RIGHT, 3'h0, 8'h01, 8'h00, 1'b0);
        do_op(acf_pkg::ACF_ROT_LEFT, 3'h0, 8'h00, 8'h00, 1'b0);
        do_op(acf_pkg::ACF_CLEAR, 3'h0, 8'h5a, 8'h00, 1'b0);
    endtask : t_logic_rot

    task automatic t_neutral();
        do_op(acf_pkg::ACF_ADD, 3'h0, 8'hff, 8'h01, 1'b0);
        do_op(acf_pkg::ACF_BIT_SET, 3'h7, 8'h00, 8'h00, 1'b0);
        do_op(acf_pkg::ACF_BIT_CLEAR, 3'h0, 8'h01, 8'h00, 1'b0);
        do_op(acf_pkg::ACF_SWAP, 3'h0, 8'h8c, 8'h00, 1'b0);
        do_op(acf_pkg::ACF_FILE_MOVE, 3'h0, 8'h80, 8'h00, 1'b0);
        do_op(acf_pkg::ACF_WORK_MOVE, 3'h0, 8'h00, 8'h7f, 1'b0);
    endtask : t_neutral

    task automatic t_dest_flags();
        do_op(acf_pkg::ACF_ADD, 3'h0, 8'h7f, 8'h01, 1'b0);
        do_op(acf_pkg::ACF_CLEAR, 3'h0, 8'h55, 8'h00, 1'b1);
        check({3'h0, alu_condition_flags}, 8'h1e);
        do_op(acf_pkg::ACF_SUB, 3'h0, 8'h00, 8'h0e, 1'b1);
        do_op(acf_pkg::ACF_BIT_SET, 3'h4, 8'h00, 8'h00, 1'b1);
        do_op(acf_pkg::ACF_BIT_CLEAR, 3'h2, 8'hff, 8'h00, 1'b1);
        do_op(acf_pkg::ACF_SWAP, 3'h0, 8'h00, 8'h00, 1'b1);
        do_op(acf_pkg::ACF_WORK_MOVE, 3'h0, 8'h00, 8'h15, 1'b1);
        do_op(acf_pkg::ACF_FILE_MOVE, 3'h0, 8'hc3, 8'h00, 1'b1);
        do_op(acf_pkg::ACF_ROT_RIGHT, 3'h0, 8'h00, 8'h00, 1'b1);
        do_op(acf_pkg::ACF_ADD, 3'h0, 8'h00, 8'h1f, 1'b1);
    endtask : t_dest_flags

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic conclude();
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    initial begin
        fails      = 0;
        n_compared = 0;
        reset_n    = 1'b0;
        t_reset();
        t_arith();
        t_logic_rot();
        t_neutral();
        t_dest_flags();
        // Second reset mid-run must clear the flags again
        t_reset();
        t_arith();
        conclude();
    end

    // About 60 cycles of work; generous margin before calling it a hang
    initial begin
        repeat (2000) @(posedge clk_sys);
        fails++;
        conclude();
    end
endmodule : tb_alu_condition_flag_register
